// File: rtl/pllcm_pkg.sv
// constants for the pll control mirror and status register bank
// assumes a 32-bit apb slave port with one aligned word per register index

package pllcm_pkg;

    // bus geometry
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 32;
    localparam int          IDX_LSB        = 2;
    localparam int          IDX_W          = 12;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_XFER       = 12'h00f;
    localparam logic [11:0] IDX_CH0_BASE   = 12'ha20;
    localparam logic [11:0] CH_STRIDE      = 12'h020;
    localparam logic [11:0] IDX_TRIM_LO    = 12'hb00;
    localparam logic [11:0] IDX_TRIM_HI    = 12'hb01;
    localparam logic [11:0] IDX_STATUS     = 12'hd01;

    // per-channel control group layout
    localparam int          NUM_CH         = 4;
    localparam int          CH_REGS        = 5;
    localparam int          CH_STORED      = 3;
    localparam logic [2:0]  REG_LOOP_RESET = 3'h3;
    localparam logic [2:0]  REG_PHASE      = 3'h4;
    localparam int          PULSE_W        = 3;
    localparam logic [23:0] CTRL_RST       = 24'h000000;

    // transfer strobe
    localparam logic [7:0]  XFER_GO        = 8'h01;

    // regulator trim
    localparam int          TRIM_W         = 10;
    localparam logic [9:0]  TRIM_RST       = 10'h000;

    // status byte fields
    localparam int          ST_LOCK        = 0;
    localparam int          ST_SETTLED     = 1;
    localparam int          ST_CAL         = 2;
    localparam int          ST_RSVD        = 3;
    localparam int          ST_ALL_LOCK    = 4;
    localparam logic [7:0]  STATUS_RST     = 8'h00;

    // apb response state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } pllcm_bus_state_type;

endpackage : pllcm_pkg

// File: rtl/pllcm_regbank.sv
// register bank: channel control mirrors, regulator trim, lock status snapshot
// assumes apb master on pclk; lock and calibration inputs arrive from other clocks

`timescale 1ns/1ps

module pllcm_regbank
    import pllcm_pkg::*;
#(
    parameter int NCH = NUM_CH
)
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [DATA_W-1:0]         pwdata,
    output logic      [DATA_W-1:0]         prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      sys_clock_locked,
    input  wire logic                      sys_clock_settled,
    input  wire logic                      sys_clock_cal_running,
    input  wire logic [NCH-1:0]            analog_loop_locked,
    input  wire logic [NCH-1:0]            digital_loop_locked,
    output logic      [NCH*CH_STORED*8-1:0] loop_control,
    output logic      [NCH*PULSE_W-1:0]    loop_reset_pulse,
    output logic      [NCH*PULSE_W-1:0]    phase_step_pulse,
    output logic      [TRIM_W-1:0]         regulator_trim
);

    localparam int SYNC_W = 3 + 2 * NCH;

    pllcm_bus_state_type state;
    pllcm_bus_state_type next_state;

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic [7:0]        snapshot;

    // ---------------- address decode ----------------
    wire [IDX_W-1:0] idx      = paddr[IDX_LSB +: IDX_W];
    wire             addr_ok  = (paddr[IDX_LSB-1:0] == '0)
                                && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == '0);
    wire             hit_xfer = addr_ok && (idx == IDX_XFER);
    wire             hit_lo   = addr_ok && (idx == IDX_TRIM_LO);
    wire             hit_hi   = addr_ok && (idx == IDX_TRIM_HI);
    wire             hit_stat = addr_ok && (idx == IDX_STATUS);

    wire [NCH-1:0]   ch_hit_vec;
    wire [NCH*8-1:0] ch_rd_vec;
    logic [7:0]      ch_rd_or;

    always_comb
    begin
        ch_rd_or = 8'h00;
        for (int i = 0; i < NCH; i++)
        begin
            ch_rd_or = ch_rd_or | ch_rd_vec[i*8 +: 8];
        end
    end

    wire hit_any   = (|ch_hit_vec) || hit_xfer || hit_lo || hit_hi || hit_stat;

    // reads are captured on the first access cycle, writes land on the completing one
    wire access    = psel && penable;
    wire rd_cap    = access && !pready;
    wire wr_commit = access && pready && pwrite;
    wire xfer_go   = wr_commit && hit_xfer && (pwdata[7:0] == XFER_GO);

    // ---------------- status path ----------------
    wire [SYNC_W-1:0] raw_status = {digital_loop_locked, analog_loop_locked,
                                    sys_clock_cal_running, sys_clock_settled,
                                    sys_clock_locked};

    // lock inputs come from the loop clock domains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_meta <= '0;
            sync_q    <= '0;
        end
        else
        begin
            sync_meta <= raw_status;
            sync_q    <= sync_meta;
        end
    end

    wire             s_lock    = sync_q[0];
    wire             s_settled = sync_q[1];
    wire             s_cal     = sync_q[2];
    wire [NCH-1:0]   s_analog  = sync_q[3 +: NCH];
    wire [NCH-1:0]   s_digital = sync_q[3+NCH +: NCH];
    wire [NCH-1:0]   all_lock  = {NCH{s_lock}} & s_analog & s_digital;

    wire [7:0] live_status;
    assign live_status[ST_LOCK]               = s_lock;
    assign live_status[ST_SETTLED]            = s_settled;
    assign live_status[ST_CAL]                = s_cal;
    assign live_status[ST_RSVD]               = 1'b0;
    assign live_status[ST_ALL_LOCK +: NUM_CH] = all_lock[NUM_CH-1:0];

    // the readable byte only moves on the strobe, so a read is coherent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            snapshot <= STATUS_RST;
        else if (xfer_go)
            snapshot <= live_status;
    end

    // ---------------- channel control mirrors ----------------
    for (genvar ch = 0; ch < NCH; ch++)
    begin : g_ch
        localparam logic [11:0] BASE = 12'(IDX_CH0_BASE + ch * CH_STRIDE);

        logic [CH_STORED*8-1:0] ctrl_q;
        logic [PULSE_W-1:0]     pulse_loop;
        logic [PULSE_W-1:0]     pulse_phase;

        wire [11:0] ch_off = idx - BASE;
        wire        ch_hit = addr_ok && (ch_off < 12'(CH_REGS));
        wire [2:0]  ch_reg = ch_off[2:0];
        wire        ch_wr  = wr_commit && ch_hit;
        // self-clearing registers and their reserved bits read back zero
        wire [7:0]  ch_rd  = !ch_hit        ? 8'h00 :
                             (ch_reg == 3'h0) ? ctrl_q[7:0] :
                             (ch_reg == 3'h1) ? ctrl_q[15:8] :
                             (ch_reg == 3'h2) ? ctrl_q[23:16] : 8'h00;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ctrl_q      <= CTRL_RST;
                pulse_loop  <= '0;
                pulse_phase <= '0;
            end
            else
            begin
                if (ch_wr && (ch_reg < 3'(CH_STORED)))
                    ctrl_q[ch_reg*8 +: 8] <= pwdata[7:0];
                pulse_loop  <= (ch_wr && ch_reg == REG_LOOP_RESET)
                               ? pwdata[PULSE_W-1:0] : '0;
                pulse_phase <= (ch_wr && ch_reg == REG_PHASE)
                               ? pwdata[PULSE_W-1:0] : '0;
            end
        end

        assign ch_hit_vec[ch]                            = ch_hit;
        assign ch_rd_vec[ch*8 +: 8]                      = ch_rd;
        assign loop_control[ch*CH_STORED*8 +: CH_STORED*8] = ctrl_q;
        assign loop_reset_pulse[ch*PULSE_W +: PULSE_W]   = pulse_loop;
        assign phase_step_pulse[ch*PULSE_W +: PULSE_W]   = pulse_phase;
    end

    // ---------------- regulator trim ----------------
    // software must keep all ten bits equal; mixed values are stored as written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            regulator_trim <= TRIM_RST;
        else if (wr_commit && hit_lo)
            regulator_trim[7:0] <= pwdata[7:0];
        else if (wr_commit && hit_hi)
            regulator_trim[9:8] <= pwdata[1:0];
    end

    // ---------------- read mux ----------------
    wire [7:0] rd_byte = ch_rd_or
                       | (hit_lo   ? regulator_trim[7:0] : 8'h00)
                       | (hit_hi   ? {6'h00, regulator_trim[9:8]} : 8'h00)
                       | (hit_stat ? snapshot : 8'h00);

    // ---------------- apb response ----------------
    always_comb
    begin
        case (state)
            BUS_IDLE: next_state = access ? BUS_DONE : BUS_IDLE;
            BUS_DONE: next_state = BUS_IDLE;
            default:  next_state = BUS_IDLE;
        endcase
    end

    // one wait state buys registered outputs on every answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= BUS_IDLE;
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            pready  <= (next_state == BUS_DONE);
            prdata  <= (rd_cap && !pwrite) ? {24'h000000, rd_byte} : '0;
            pslverr <= rd_cap && !hit_any;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence strobe_s;
        xfer_go;
    endsequence

    sequence stat_wr_s;
        wr_commit && hit_stat;
    endsequence

    sequence hi_wr_s;
        wr_commit && hit_hi;
    endsequence

    sequence lo_wr_s;
        wr_commit && hit_lo;
    endsequence

    sequence stat_rd_s;
        rd_cap && !pwrite && hit_stat;
    endsequence

    sequence bad_xfer_s;
        wr_commit && hit_xfer && (pwdata[7:0] != XFER_GO);
    endsequence

    // a trim write changes only its own bits (7:0 or 9:8); the other trim bits keep their value
    trim_hi_store_a: assert property (hi_wr_s
                                      |=> regulator_trim[9:8] == $past(pwdata[1:0]))
        else $error("trim high bits not stored");

    trim_lo_keep_a: assert property (hi_wr_s
                                     |=> regulator_trim[7:0] == $past(regulator_trim[7:0]))
        else $error("trim high write disturbed low bits");

    trim_lo_hold_a: assert property (lo_wr_s
                                     |=> regulator_trim[9:8] == $past(regulator_trim[9:8]))
        else $error("trim low write disturbed high bits");

    trim_hold_a: assert property (!(wr_commit && (hit_lo || hit_hi))
                                  |=> $stable(regulator_trim))
        else $error("trim moved without a trim write");

    // software only ever sees the snapshot, never the live inputs
    stat_read_a: assert property (stat_rd_s
                                  |=> prdata == {24'h000000, $past(snapshot)})
        else $error("status read does not return the snapshot");

    bad_strobe_a: assert property (bad_xfer_s |=> $stable(snapshot))
        else $error("snapshot refreshed by a wrong strobe value");

    stat_rsvd_a: assert property (snapshot[ST_RSVD] == 1'b0)
        else $error("reserved status bit set");

    snap_refresh_a: assert property (strobe_s |=> snapshot == $past(live_status))
        else $error("status snapshot not refreshed by strobe");

    snap_hold_a: assert property (!xfer_go |=> $stable(snapshot))
        else $error("status snapshot moved without strobe");

    status_ro_a: assert property (stat_wr_s |=> $stable(snapshot) ##1 $stable(snapshot))
        else $error("write to status byte changed it");

    all_lock_a: assert property (strobe_s and !s_lock |=> snapshot[7:4] == 4'h0)
        else $error("all locked bit set while system loop unlocked");

    loop_lock_a: assert property (strobe_s |=> snapshot[7:4] == $past(s_analog & s_digital
                                  & {NCH{s_lock}}))
        else $error("all locked bits disagree with loop locks");

    cal_busy_a: assert property (strobe_s |=> snapshot[3] == 1'b0 && snapshot[2] == $past(s_cal))
        else $error("calibration or reserved status bit wrong");

    sys_stable_a: assert property (strobe_s |=> snapshot[1] == $past(s_settled))
        else $error("settled bit does not follow stability input");

    sys_lock_a: assert property (strobe_s |=> snapshot[0] == $past(s_lock))
        else $error("lock bit does not follow lock detector");

    trim_high_a: assert property (rd_cap && !pwrite && hit_hi |=> prdata[31:2] == 30'h0
                                  && prdata[1:0] == $past(regulator_trim[9:8]))
        else $error("trim high read shows wrong or reserved bits");

    for (genvar ch = 0; ch < NCH; ch++)
    begin : g_chk
        sequence reg0_wr_s;
            wr_commit && ch_hit_vec[ch] && g_ch[ch].ch_reg == 3'h0;
        endsequence

        mirror_write_a: assert property (reg0_wr_s |=> loop_control[ch*24 +: 8]
                                         == $past(pwdata[7:0]))
            else $error("mirrored control write not stored");

        chan_isolate_a: assert property (!(wr_commit && ch_hit_vec[ch])
                                         |=> $stable(g_ch[ch].ctrl_q))
            else $error("control group changed by another channel write");

        self_clear_a: assert property (wr_commit && ch_hit_vec[ch]
                                       && g_ch[ch].ch_reg == REG_LOOP_RESET
                                       |=> loop_reset_pulse[ch*3 +: 3] == $past(pwdata[2:0])
                                       ##1 loop_reset_pulse[ch*3 +: 3] == 3'h0)
            else $error("loop reset bits did not pulse and self-clear");

        sequence phase_wr_s;
            wr_commit && ch_hit_vec[ch] && g_ch[ch].ch_reg == REG_PHASE;
        endsequence

        phase_clear_a: assert property (phase_wr_s
                                        |=> phase_step_pulse[ch*3 +: 3] == $past(pwdata[2:0])
                                        ##1 phase_step_pulse[ch*3 +: 3] == 3'h0)
            else $error("phase step bits did not pulse and self-clear");

        // a stray pulse would reset a loop that software never touched
        pulse_idle_a: assert property (!(wr_commit && ch_hit_vec[ch])
                                       |=> loop_reset_pulse[ch*3 +: 3] == 3'h0
                                       && phase_step_pulse[ch*3 +: 3] == 3'h0)
            else $error("pulse bits set without a control write");

        pulse_read_a: assert property (rd_cap && !pwrite && ch_hit_vec[ch]
                                       && g_ch[ch].ch_reg >= REG_LOOP_RESET
                                       |=> prdata == 32'h00000000)
            else $error("self-clearing register reads nonzero");
    end

endmodule : pllcm_regbank

// File: tb/tb_top.sv
// self-checking bench for the pll control mirror and status register bank
// assumes one wait state apb answers and 2-flop sync on the lock inputs
`timescale 1ns/1ps

module tb_top;
    import pllcm_pkg::*;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [15:0]       paddr = 16'h0000;
    logic [31:0]       pwdata = 32'h00000000;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              sys_clock_locked = 1'b0;
    logic              sys_clock_settled = 1'b0;
    logic              sys_clock_cal_running = 1'b0;
    logic [3:0]        analog_loop_locked = 4'h0;
    logic [3:0]        digital_loop_locked = 4'h0;
    logic [95:0]       loop_control;
    logic [11:0]       loop_reset_pulse;
    logic [11:0]       phase_step_pulse;
    logic [9:0]        regulator_trim;
    logic [95:0]       exp_lc = 96'h0;
    int                n_fail = 0;
    int                compares = 0;

    always #50 pclk = ~pclk;

    pllcm_regbank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_clock_locked(sys_clock_locked),
        .sys_clock_settled(sys_clock_settled), .sys_clock_cal_running(sys_clock_cal_running),
        .analog_loop_locked(analog_loop_locked), .digital_loop_locked(digital_loop_locked),
        .loop_control(loop_control), .loop_reset_pulse(loop_reset_pulse),
        .phase_step_pulse(phase_step_pulse), .regulator_trim(regulator_trim));

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] ba(input logic [11:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // request held until pready is sampled high; gives up and fails after 20 cycles
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
        chk({95'h0, e}, 96'h0);
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 8'h00, rd, e);
        chk({63'h0, e, rd}, {88'h0, exp});
    endtask : rdchk

    task automatic t_defaults;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 5; r++)
                rdchk(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + r)), 8'h00);
        rdchk(ba(IDX_TRIM_LO), 8'h00);
        rdchk(ba(IDX_TRIM_HI), 8'h00);
        rdchk(ba(IDX_STATUS), 8'h00);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_mirror;
        logic [7:0] d;
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 3; r++)
            begin
                d = 8'(c * 16 + r + 1);
                exp_lc[c * 24 + r * 8 +: 8] = d;
                wr(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + r)), d);
            end
            #1 chk(loop_control, exp_lc);
        end
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 3; r++)
                rdchk(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + r)), 8'(c * 16 + r + 1));
        $display("test mirror done");
    endtask : t_mirror

    task automatic t_trim;
        wr(ba(IDX_TRIM_LO), 8'hff);
        wr(ba(IDX_TRIM_HI), 8'hff);
        #1 chk(96'(regulator_trim), 96'h3ff);
        rdchk(ba(IDX_TRIM_HI), 8'h03);
        rdchk(ba(IDX_TRIM_LO), 8'hff);
        wr(ba(IDX_TRIM_LO), 8'h00);
        wr(ba(IDX_TRIM_HI), 8'h00);
        #1 chk(96'(regulator_trim), 96'h0);
        $display("test trim done");
    endtask : t_trim

    task automatic t_pulse;
        for (int c = 0; c < 4; c++)
        begin
            wr(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + 3)), 8'h07);
            #1 chk(96'(loop_reset_pulse), 96'(12'h7 << (c * 3)));
            @(posedge pclk);
            #1 chk(96'(loop_reset_pulse), 96'h0);
            rdchk(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + 3)), 8'h00);
            wr(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + 4)), 8'h05);
            #1 chk(96'(phase_step_pulse), 96'(12'h5 << (c * 3)));
            @(posedge pclk);
            #1 chk(96'(phase_step_pulse), 96'h0);
            rdchk(ba(12'(IDX_CH0_BASE + CH_STRIDE * c + 4)), 8'h00);
        end
        #1 chk(loop_control, exp_lc);
        $display("test pulse done");
    endtask : t_pulse

    // new inputs only show after a strobe; the old snapshot must stay readable
    task automatic snap(input logic [2:0] lsc, input logic [7:0] al, input logic [7:0] old,
                        input logic [7:0] exp);
        @(posedge pclk);
        sys_clock_locked <= lsc[2];
        sys_clock_settled <= lsc[1];
        sys_clock_cal_running <= lsc[0];
        analog_loop_locked <= al[7:4];
        digital_loop_locked <= al[3:0];
        repeat (4) @(posedge pclk);
        rdchk(ba(IDX_STATUS), old);
        wr(ba(IDX_XFER), 8'h02);
        rdchk(ba(IDX_STATUS), old);
        wr(ba(IDX_XFER), XFER_GO);
        rdchk(ba(IDX_STATUS), exp);
        wr(ba(IDX_STATUS), 8'hff);
        rdchk(ba(IDX_STATUS), exp);
    endtask : snap

    task automatic t_status;
        snap(3'b111, 8'hb7, 8'h00, 8'h37);
        snap(3'b010, 8'hff, 8'h37, 8'h02);
        snap(3'b100, 8'hff, 8'h02, 8'hf1);
        $display("test status done");
    endtask : t_status

    task automatic t_err;
        logic [31:0] rd;
        logic        e;
        apb(1'b0, ba(12'hc00), 8'h00, rd, e);
        chk({63'h0, e, rd}, {63'h0, 1'b1, 32'h0});
        apb(1'b1, ba(IDX_CH0_BASE) | 16'h0001, 8'h5a, rd, e);
        chk({95'h0, e}, 96'h1);
        rdchk(ba(IDX_CH0_BASE), 8'h01);
        $display("test errors done");
    endtask : t_err

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_mirror();
        t_trim();
        t_pulse();
        t_status();
        t_err();
        print_verdict();
    end

endmodule : tb_top
